// ===== rtl/viterbi_map.svh
// Constants for the eight-state trellis decoder: sizes, reset values and limits
`ifndef VITERBI_MAP_SVH
`define VITERBI_MAP_SVH

`define VIT_NUM_STATES      8
`define VIT_STATE_W         3
`define VIT_TRANS_W         3
`define VIT_METRIC_W        16
`define VIT_BRANCH_W        2
`define VIT_CAND_NUM        4
`define VIT_TB_DEPTH        16
`define VIT_TIME_W          4
`define VIT_TB_LAST         4'hF
`define VIT_TIME_ZERO       4'h0
`define VIT_INIT_METRIC0    16'h0000
`define VIT_INIT_METRIC     16'h0010
`define VIT_MAX_SYMBOLS     21840

`endif

// ===== rtl/viterbi_pkg.sv
// Types shared by the trellis decoder and its history memory
`include "viterbi_map.svh"

package viterbi_pkg;

  typedef logic [`VIT_STATE_W-1:0]  state_idx_t;
  typedef logic [`VIT_TRANS_W-1:0]  transition_t;
  typedef logic [`VIT_METRIC_W-1:0] metric_t;
  typedef logic [`VIT_BRANCH_W-1:0] branch_metric_t;
  typedef logic [`VIT_TIME_W-1:0]   time_idx_t;

  // One survivor record: where the path came from and by which transition
  typedef struct packed {
    state_idx_t  pred;
    transition_t trans;
  } hist_entry_t;

  typedef hist_entry_t [`VIT_NUM_STATES-1:0]    hist_row_t;
  typedef metric_t [`VIT_NUM_STATES-1:0]        metric_vec_t;
  typedef branch_metric_t [`VIT_NUM_STATES-1:0] branch_vec_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACS,
    ST_COPY,
    ST_TB_ADDR,
    ST_TB_DATA
  } fsm_state_t;

endpackage : viterbi_pkg

// ===== rtl/history_mem.sv
// Circular survivor history: one row of eight records per symbol period
`timescale 1ns/100ps
`include "viterbi_map.svh"

module history_mem (
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  wr_en_i,
  input  wire viterbi_pkg::time_idx_t wr_addr_i,
  input  wire viterbi_pkg::hist_row_t wr_row_i,
  input  wire viterbi_pkg::time_idx_t rd_addr_i,
  output viterbi_pkg::hist_row_t     rd_row_o
);

  viterbi_pkg::hist_row_t mem_q [`VIT_TB_DEPTH];
  viterbi_pkg::hist_row_t mem_d [`VIT_TB_DEPTH];
  viterbi_pkg::hist_row_t rd_row_q;
  viterbi_pkg::hist_row_t rd_row_d;

  // Next contents: one row replaced per write, reset clears all to the null path
  always_comb begin
    for (int i = 0; i < `VIT_TB_DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (wr_en_i) begin
      mem_d[wr_addr_i] = wr_row_i;
    end
    rd_row_d = mem_q[rd_addr_i];
  end

  // Registered read; a row written this edge is visible one cycle later
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < `VIT_TB_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      rd_row_q <= '0;
    end else begin
      for (int i = 0; i < `VIT_TB_DEPTH; i++) begin
        mem_q[i] <= mem_d[i];
      end
      rd_row_q <= rd_row_d;
    end
  end

  assign rd_row_o = rd_row_q;

endmodule : history_mem

// ===== rtl/viterbi_acs_traceback.sv
// Eight-state trellis decoder: branch metrics, add-compare-select and traceback
//
// Behaviour
// [R1] Upstream delivers one 3-bit received transition per symbol period.
// [R2] Reset clears histories, metric of state zero is zero, others sixteen.
// [R3] Even new states come from past states 0-3, odd from 4-7.
// [R4] Branch metric per transition is Hamming distance to the received symbol.
// [R5] Four candidate totals per new state: predecessor metric plus branch metric.
// [R6] Path metrics are unsigned 16 bits, wrap past 65535, never renormalised.
// [R7] User keeps a run below 21840 symbols so metrics cannot overflow.
// [R8] Smallest of four candidates survives; the other three are dropped.
// [R9] One survivor per state per period, so eight survivor paths exist.
// [R10] New metrics go to a separate buffer while comparisons still run.
// [R11] Buffer copied into the metric store only after all eight are chosen.
// [R12] Selected predecessor stored at entry indexed by current time and state.
// [R13] Selected transition stored at entry indexed by current time and state.
// [R14] Each period the smallest path metric's state starts the traceback.
// [R15] Traceback walks back depth minus one periods along the chosen path.
// [R16] Traceback index starts at current time and decreases every step.
// [R17] Each step reads the trace state's predecessor and makes it current.
// [R18] Traceback index wraps from below zero to depth minus one.
// [R19] Output is the stored transition of the oldest trace state reached.
// [R20] Each output lags its input symbol by depth minus one periods.
// [R21] Redundant top bit is dropped; the 2-bit symbol is output each period.
// [R22] Ties in candidates or metrics pick the lowest-numbered one.
`timescale 1ns/100ps
`include "viterbi_map.svh"

module viterbi_acs_traceback (
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic                    sym_valid_i,
  input  wire viterbi_pkg::transition_t sym_i,
  output logic                         sym_ready_o,
  output logic                         out_valid_o,
  output logic [1:0]                   decoded_symbol_pair_o
);

  // Hamming distance between two 3-bit transitions
  function automatic viterbi_pkg::branch_metric_t hamming(
    input viterbi_pkg::transition_t a,
    input viterbi_pkg::transition_t b
  );
    viterbi_pkg::transition_t x;
    x = a ^ b;
    return 2'(x[0]) + 2'(x[1]) + 2'(x[2]);
  endfunction : hamming

  // Past state feeding candidate k of a new state
  function automatic viterbi_pkg::state_idx_t cand_pred(
    input viterbi_pkg::state_idx_t s,
    input logic [1:0]              k
  );
    return {s[0], k}; // see [R3]
  endfunction : cand_pred

  // Transition on the branch from candidate k into new state s
  function automatic viterbi_pkg::transition_t cand_trans(
    input viterbi_pkg::state_idx_t s,
    input logic [1:0]              k
  );
    viterbi_pkg::transition_t tr;
    tr = 3'h0;
    // Even states only see the lower four transitions, odd states the upper four
    unique case ({s, k})
      5'h00: tr = 3'h0;
      5'h01: tr = 3'h2;
      5'h02: tr = 3'h3;
      5'h03: tr = 3'h1;
      5'h04: tr = 3'h4;
      5'h05: tr = 3'h7;
      5'h06: tr = 3'h6;
      5'h07: tr = 3'h5;
      5'h08: tr = 3'h2;
      5'h09: tr = 3'h0;
      5'h0A: tr = 3'h1;
      5'h0B: tr = 3'h3;
      5'h0C: tr = 3'h7;
      5'h0D: tr = 3'h4;
      5'h0E: tr = 3'h5;
      5'h0F: tr = 3'h6;
      5'h10: tr = 3'h3;
      5'h11: tr = 3'h1;
      5'h12: tr = 3'h0;
      5'h13: tr = 3'h2;
      5'h14: tr = 3'h5;
      5'h15: tr = 3'h6;
      5'h16: tr = 3'h7;
      5'h17: tr = 3'h4;
      5'h18: tr = 3'h1;
      5'h19: tr = 3'h3;
      5'h1A: tr = 3'h2;
      5'h1B: tr = 3'h0;
      5'h1C: tr = 3'h6;
      5'h1D: tr = 3'h5;
      5'h1E: tr = 3'h4;
      5'h1F: tr = 3'h7;
    endcase
    return tr;
  endfunction : cand_trans

  // Control and data registers
  viterbi_pkg::fsm_state_t  fsm_q, fsm_d;
  viterbi_pkg::transition_t sym_q, sym_d;
  viterbi_pkg::time_idx_t   tcurr_q, tcurr_d;
  viterbi_pkg::time_idx_t   traceback_time_index_q, traceback_time_index_d;
  viterbi_pkg::time_idx_t   tb_step_q, tb_step_d;
  viterbi_pkg::state_idx_t  current_trace_state_q, current_trace_state_d;
  viterbi_pkg::metric_vec_t path_metric_store_q, path_metric_store_d;
  viterbi_pkg::metric_vec_t next_path_metric_store_q, next_path_metric_store_d;
  logic                     ready_q, ready_d;
  logic                     out_valid_q, out_valid_d;
  logic [1:0]               out_sym_q, out_sym_d;

  // Combinational results
  viterbi_pkg::branch_vec_t branch_metric_set;
  viterbi_pkg::metric_vec_t acs_metric;
  viterbi_pkg::hist_row_t   acs_row;
  viterbi_pkg::hist_row_t   rd_row;
  viterbi_pkg::hist_entry_t rd_entry;
  viterbi_pkg::state_idx_t  min_state;
  viterbi_pkg::metric_t     minimum_path_metric;
  viterbi_pkg::state_idx_t  previous_trace_state;

  // Eight branch metrics of the latched symbol
  for (genvar t = 0; t < `VIT_NUM_STATES; t++) begin : g_branch
    assign branch_metric_set[t] = hamming(sym_q, 3'(t)); // see [R4]
  end

  // One add-compare-select unit per new state, all in parallel
  for (genvar s = 0; s < `VIT_NUM_STATES; s++) begin : g_acs
    viterbi_pkg::metric_t cand [`VIT_CAND_NUM];
    logic [1:0]           best;

    for (genvar k = 0; k < `VIT_CAND_NUM; k++) begin : g_cand
      // Plain 16-bit sum: wraps rather than saturates, caller bounds run length
      assign cand[k] = path_metric_store_q[cand_pred(3'(s), 2'(k))]
                     + 16'(branch_metric_set[cand_trans(3'(s), 2'(k))]); // see [R5] [R6] [R7]
    end

    // Strict compare keeps the lowest-numbered candidate on a tie
    always_comb begin
      best = 2'h0;
      for (int k = 1; k < `VIT_CAND_NUM; k++) begin
        if (cand[k] < cand[best]) begin // see [R8] [R22]
          best = 2'(k);
        end
      end
    end

    assign acs_metric[s]    = cand[best];
    assign acs_row[s].pred  = cand_pred(3'(s), best);  // see [R9] [R12]
    assign acs_row[s].trans = cand_trans(3'(s), best); // see [R13]
  end

  // Smallest finished metric, lowest state on a tie
  always_comb begin
    min_state           = 3'h0;
    minimum_path_metric = next_path_metric_store_q[0];
    for (int i = 1; i < `VIT_NUM_STATES; i++) begin
      if (next_path_metric_store_q[i] < minimum_path_metric) begin // see [R14] [R22]
        min_state           = 3'(i);
        minimum_path_metric = next_path_metric_store_q[i];
      end
    end
  end

  // Record of the current trace state in the row just read
  assign rd_entry             = rd_row[current_trace_state_q];
  assign previous_trace_state = rd_entry.pred;

  // Survivor history, written once per period at the current time column
  history_mem history_mem_i (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .wr_en_i   (fsm_q == viterbi_pkg::ST_ACS),
    .wr_addr_i (tcurr_q),
    .wr_row_i  (acs_row),
    .rd_addr_i (traceback_time_index_q),
    .rd_row_o  (rd_row)
  );

  // Sequencer: accept, select, commit metrics, then walk the history
  always_comb begin
    fsm_d                  = fsm_q;
    sym_d                  = sym_q;
    tcurr_d                = tcurr_q;
    traceback_time_index_d = traceback_time_index_q;
    tb_step_d              = tb_step_q;
    current_trace_state_d  = current_trace_state_q;
    unique case (fsm_q)
      viterbi_pkg::ST_IDLE: begin
        // Ready is still low in the first idle cycle after reset; nothing is taken then
        if (sym_valid_i && ready_q) begin // see [R1]
          sym_d = sym_i;
          fsm_d = viterbi_pkg::ST_ACS;
        end
      end
      viterbi_pkg::ST_ACS: begin
        fsm_d = viterbi_pkg::ST_COPY;
      end
      viterbi_pkg::ST_COPY: begin
        current_trace_state_d  = min_state; // see [R14]
        traceback_time_index_d = tcurr_q;   // see [R16]
        tb_step_d              = `VIT_TIME_ZERO;
        fsm_d                  = viterbi_pkg::ST_TB_ADDR;
      end
      viterbi_pkg::ST_TB_ADDR: begin
        // Memory read takes one cycle; index is already on its address
        fsm_d = viterbi_pkg::ST_TB_DATA;
      end
      viterbi_pkg::ST_TB_DATA: begin
        if (tb_step_q == `VIT_TB_LAST) begin // see [R15]
          tcurr_d = (tcurr_q == `VIT_TB_LAST) ? `VIT_TIME_ZERO : tcurr_q + 4'h1;
          fsm_d   = viterbi_pkg::ST_IDLE;
        end else begin
          current_trace_state_d  = previous_trace_state; // see [R17]
          traceback_time_index_d = (traceback_time_index_q == `VIT_TIME_ZERO)
                                 ? `VIT_TB_LAST                   // see [R18]
                                 : traceback_time_index_q - 4'h1; // see [R16]
          tb_step_d              = tb_step_q + 4'h1;
          fsm_d                  = viterbi_pkg::ST_TB_ADDR;
        end
      end
    endcase
  end

  // Control registers; symbols offered while busy are dropped, only ready tells
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      fsm_q                  <= viterbi_pkg::ST_IDLE;
      sym_q                  <= 3'h0;
      tcurr_q                <= `VIT_TIME_ZERO;
      traceback_time_index_q <= `VIT_TIME_ZERO;
      tb_step_q              <= `VIT_TIME_ZERO;
      current_trace_state_q  <= 3'h0;
    end else begin
      fsm_q                  <= fsm_d;
      sym_q                  <= sym_d;
      tcurr_q                <= tcurr_d;
      traceback_time_index_q <= traceback_time_index_d;
      tb_step_q              <= tb_step_d;
      current_trace_state_q  <= current_trace_state_d;
    end
  end

  // Metric group: old store stays frozen until every state is decided
  always_comb begin
    path_metric_store_d      = path_metric_store_q;
    next_path_metric_store_d = next_path_metric_store_q;
    if (fsm_q == viterbi_pkg::ST_ACS) begin
      next_path_metric_store_d = acs_metric; // see [R10]
    end
    if (fsm_q == viterbi_pkg::ST_COPY) begin
      path_metric_store_d = next_path_metric_store_q; // see [R11]
    end
  end

  // Metric registers; reset gives state zero metric zero and every other state sixteen
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < `VIT_NUM_STATES; i++) begin
        path_metric_store_q[i]      <= (i == 0) ? `VIT_INIT_METRIC0 : `VIT_INIT_METRIC; // see [R2]
        next_path_metric_store_q[i] <= (i == 0) ? `VIT_INIT_METRIC0 : `VIT_INIT_METRIC;
      end
    end else begin
      path_metric_store_q      <= path_metric_store_d;
      next_path_metric_store_q <= next_path_metric_store_d;
    end
  end

  // Output group: one-cycle pulse, pair held until the next decision
  always_comb begin
    ready_d     = (fsm_d == viterbi_pkg::ST_IDLE);
    out_valid_d = 1'b0;
    out_sym_d   = out_sym_q;
    if (fsm_q == viterbi_pkg::ST_TB_DATA && tb_step_q == `VIT_TB_LAST) begin
      out_sym_d   = rd_entry.trans[1:0]; // see [R19] [R21]
      out_valid_d = 1'b1;                // see [R20]
    end
  end

  // Output registers; ready comes back in the same edge as the pulse
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ready_q     <= 1'b0;
      out_valid_q <= 1'b0;
      out_sym_q   <= 2'h0;
    end else begin
      ready_q     <= ready_d;
      out_valid_q <= out_valid_d;
      out_sym_q   <= out_sym_d;
    end
  end

  // Outputs straight from flops
  assign sym_ready_o           = ready_q;
  assign out_valid_o           = out_valid_q;
  assign decoded_symbol_pair_o = out_sym_q;

endmodule : viterbi_acs_traceback

// ===== dv/viterbi_checker.sv
// Port-level timing checks for the trellis decoder
`timescale 1ns/100ps
module viterbi_checker (
  input wire logic                     ref_clk_i,
  input wire logic                     reset_n_i,
  input wire logic                     sym_valid_i,
  input wire viterbi_pkg::transition_t sym_i,
  input wire logic                     sym_ready_o,
  input wire logic                     out_valid_o,
  input wire logic [1:0]               decoded_symbol_pair_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic       take;
  logic [5:0] busy_d;
  logic [5:0] busy_q;
  assign take = sym_valid_i && sym_ready_o;
  // Cycles since the last take; a refused symbol must not restart it
  always_comb begin
    busy_d = 6'h00;
    if (take) busy_d = 6'h01;
    else if (busy_q != 6'h00 && !sym_ready_o) busy_d = busy_q + 6'h01;
  end
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) busy_q <= 6'h00;
    else busy_q <= busy_d;
  end
  property p_take_quiet;
    take |=> (!sym_ready_o && !out_valid_o) [*8];
  endproperty
  a_take_quiet: assert property (p_take_quiet) else $error("early flags after take");
  property p_busy_quiet;
    (busy_q != 6'h00 && busy_q < 6'h23) |-> (!sym_ready_o && !out_valid_o);
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("flags during busy");
  property p_answer;
    take |-> ##35 (out_valid_o && sym_ready_o);
  endproperty
  a_answer: assert property (p_answer) else $error("answer not on time");
  property p_pulse;
    out_valid_o |=> !out_valid_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("output pulse too long");
  property p_pair_hold;
    !out_valid_o |-> $stable(decoded_symbol_pair_o);
  endproperty
  a_pair_hold: assert property (p_pair_hold) else $error("pair moved without pulse");
  property p_reset;
    $rose(reset_n_i) |-> (!sym_ready_o && !out_valid_o && decoded_symbol_pair_o == 2'h0)
      ##1 sym_ready_o;
  endproperty
  a_reset: assert property (p_reset) else $error("bad state after reset");
  property p_idle;
    (sym_ready_o && !sym_valid_i) |=> (sym_ready_o && !out_valid_o);
  endproperty
  a_idle: assert property (p_idle) else $error("idle decoder moved");
  property p_one_answer;
    out_valid_o |-> busy_q == 6'h23;
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("pulse without take");
endmodule : viterbi_checker
bind viterbi_acs_traceback viterbi_checker viterbi_checker_i (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .sym_valid_i(sym_valid_i), .sym_i(sym_i),
  .sym_ready_o(sym_ready_o), .out_valid_o(out_valid_o),
  .decoded_symbol_pair_o(decoded_symbol_pair_o));

// ===== dv/sym_source.sv
// Upstream symbol source model feeding the trellis decoder
`timescale 1ns/100ps
module sym_source (
  input  wire logic                     ref_clk_i,
  input  wire logic                     sym_ready_i,
  input  wire logic                     req_i,
  input  wire logic                     early_i,
  input  wire viterbi_pkg::transition_t data_i,
  output logic                          sym_valid_o,
  output viterbi_pkg::transition_t      sym_o,
  output logic                          taken_o
);
  initial begin
    sym_valid_o = 1'b0;
    sym_o = 3'h0;
    taken_o = 1'b0;
  end
  // Acceptance as seen at the sampling edge
  always @(posedge ref_clk_i) begin
    taken_o <= sym_valid_o && sym_ready_i;
  end
  // One symbol per period; early mode holds valid through a busy decoder
  always @(negedge ref_clk_i) begin
    if (!sym_valid_o && req_i && (sym_ready_i || early_i)) begin
      sym_valid_o <= 1'b1;
      sym_o <= data_i;
    end else if (!sym_valid_o || taken_o) begin
      sym_valid_o <= 1'b0;
      sym_o <= ~sym_o; // Released bus never keeps the old value
    end
  end
endmodule : sym_source

// ===== dv/viterbi_acs_traceback_bench.sv
// Self-checking bench for the trellis decoder with a reference trellis model
`timescale 1ns/100ps
module viterbi_acs_traceback_bench;
  localparam logic [2:0] trellis_tab [32] = '{
    3'h0, 3'h2, 3'h3, 3'h1, 3'h4, 3'h7, 3'h6, 3'h5,
    3'h2, 3'h0, 3'h1, 3'h3, 3'h7, 3'h4, 3'h5, 3'h6,
    3'h3, 3'h1, 3'h0, 3'h2, 3'h5, 3'h6, 3'h7, 3'h4,
    3'h1, 3'h3, 3'h2, 3'h0, 3'h6, 3'h5, 3'h4, 3'h7};
  localparam logic [2:0] corner_tab [20] = '{
    3'h0, 3'h2, 3'h0, 3'h3, 3'h6, 3'h5, 3'h3, 3'h5, 3'h1, 3'h0,
    3'h2, 3'h6, 3'h5, 3'h1, 3'h4, 3'h7, 3'h7, 3'h7, 3'h7, 3'h3};
  logic                     ref_clk_i = 1'b0;
  logic                     reset_n_i = 1'b0;
  logic                     req = 1'b0;
  logic                     early = 1'b0;
  viterbi_pkg::transition_t data = 3'h0;
  viterbi_pkg::transition_t sym;
  logic                     sym_valid;
  logic                     sym_ready;
  logic                     out_valid;
  logic                     taken;
  logic [1:0]               pair;
  logic [1:0]               exp_q [$];
  logic [15:0]              pm [8];
  logic [2:0]               hp [16][8];
  logic [2:0]               ht [16][8];
  int                       tc;
  int                       lat = 0;
  int                       error_cnt = 0;
  int                       num_checks = 0;

  always #20 ref_clk_i = ~ref_clk_i;

  sym_source sym_source_i (.ref_clk_i(ref_clk_i), .sym_ready_i(sym_ready), .req_i(req),
    .early_i(early), .data_i(data), .sym_valid_o(sym_valid), .sym_o(sym), .taken_o(taken));
  viterbi_acs_traceback viterbi_acs_traceback_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .sym_valid_i(sym_valid), .sym_i(sym), .sym_ready_o(sym_ready), .out_valid_o(out_valid),
    .decoded_symbol_pair_o(pair));

  task automatic check(input logic [31:0] seen, input logic [31:0] expct);
    num_checks++;
    if (seen !== expct) begin
      error_cnt++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, expct);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // Reference decoder step: whole trellis in one call, then a full traceback
  function automatic logic [1:0] ref_step(input logic [2:0] r);
    logic [15:0] nm [8];
    logic [15:0] c;
    logic [2:0]  p;
    logic [2:0]  s;
    int          t;
    for (int n = 0; n < 8; n++) begin
      for (int k = 0; k < 4; k++) begin
        p = 3'(n % 2 * 4 + k);
        c = pm[p] + 16'($countones(r ^ trellis_tab[n * 4 + k]));
        if (k == 0 || c < nm[n]) begin
          nm[n] = c;
          hp[tc][n] = p;
          ht[tc][n] = trellis_tab[n * 4 + k];
        end
      end
    end
    s = 3'h0;
    for (int n = 0; n < 8; n++) begin
      pm[n] = nm[n];
      if (nm[n] < nm[s]) s = 3'(n);
    end
    t = tc;
    repeat (15) begin
      s = hp[t][s];
      t = (t + 15) % 16;
    end
    tc = (tc + 1) % 16;
    return ht[t][s][1:0];
  endfunction : ref_step

  // Reset the decoder and the reference model together
  task automatic do_reset();
    @(negedge ref_clk_i);
    reset_n_i <= 1'b0;
    repeat (3) @(negedge ref_clk_i);
    check(sym_ready, 0);
    check({out_valid, pair}, 0);
    reset_n_i <= 1'b1;
    exp_q.delete();
    tc = 0;
    for (int i = 0; i < 8; i++) pm[i] = (i == 0) ? 16'h0000 : 16'h0010;
    foreach (hp[i, j]) hp[i][j] = 3'h0;
    foreach (ht[i, j]) ht[i][j] = 3'h0;
  endtask : do_reset

  task automatic send(input logic [2:0] d, input logic e);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    req <= 1'b1;
    data <= d;
    early <= e;
    @(negedge ref_clk_i);
    while (taken !== 1'b1 && n < 100) begin
      @(negedge ref_clk_i);
      n++;
    end
    req <= 1'b0;
    if (n == 100) check(1, 0);
    else exp_q.push_back(ref_step(d));
  endtask : send

  task automatic drain(input string name);
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 100) begin
      @(negedge ref_clk_i);
      n++;
    end
    check(exp_q.size(), 0);
    $display("test %s done", name);
  endtask : drain

  // Output monitor: latency from the take and the decided pair
  always @(negedge ref_clk_i) begin
    if (reset_n_i === 1'b1) begin
      lat = (taken === 1'b1) ? 0 : lat + 1;
      if (out_valid === 1'b1) begin
        check(lat, 34);
        if (exp_q.size() == 0) check(1, 0);
        else check(pair, exp_q.pop_front());
      end
    end
  end

  // Watchdog sized well above the expected run of about 4300 cycles
  initial begin
    #(40 * 20000);
    error_cnt++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'hFC5A88BB));
    do_reset();
    repeat (18) send(3'h0, 1'b0);
    drain("null_path");
    foreach (corner_tab[i]) send(corner_tab[i], i[0]);
    drain("noisy_path");
    // Runs stay far below the overflow limit, so metrics never wrap here
    repeat (60) send(3'($urandom_range(7, 0)), 1'($urandom_range(1, 0)));
    drain("random");
    send(3'h5, 1'b0);
    repeat (10) @(negedge ref_clk_i);
    do_reset();
    repeat (20) send(3'($urandom_range(7, 0)), 1'b1);
    drain("mid_reset");
    end_of_test();
  end
endmodule : viterbi_acs_traceback_bench
